// ===== frled_pkg.sv
// What this block does
// - Reaction 0: warning only, no action
// - Reaction 1: signal, disable power stage
// - Reaction 2: quick-stop, wait start withdrawn
// - Reaction 3: disable stage, block autorestart
// - Reaction 4: quick-stop, wait, block autorestart
// - Reaction 5: disable, reset only by power-off
// - Restart block only with autostart programmed
// - Green on; yellow ready on, enabled flashing
// - Warning while enabled: yellow flashes, green on
// - Error: yellow off, red flash code
// - Undervoltage: two flashes, reaction one
// - Overload/overtemp errors: reaction 3, counts 5-8
// - Report error location number to keypad
`default_nettype none
package frled_pkg;
  localparam logic [2:0] REACT_WARN     = 3'h0;
  localparam logic [2:0] REACT_DISABLE  = 3'h1;
  localparam logic [2:0] REACT_QSTOP    = 3'h2;
  localparam logic [2:0] REACT_LOCK     = 3'h3;
  localparam logic [2:0] REACT_QS_LOCK  = 3'h4;
  localparam logic [2:0] REACT_POWERCUT = 3'h5;
  localparam logic [3:0] FLASH_GENERIC  = 4'h1;
  localparam logic [3:0] FLASH_UNDERV   = 4'h2;
  localparam logic [3:0] FLASH_OVERCUR  = 4'h3;
  localparam logic [3:0] FLASH_OVERVOLT = 4'h4;
  localparam logic [3:0] FLASH_MOT_OVLD = 4'h5;
  localparam logic [3:0] FLASH_DEV_OVLD = 4'h6;
  localparam logic [3:0] FLASH_MOT_HOT  = 4'h7;
  localparam logic [3:0] FLASH_DEV_HOT  = 4'h8;
  localparam int CLK_HZ        = 50000000;
  localparam int FLASH_MS      = 250;
  localparam int PAUSE_MS      = 1000;
  localparam int FLASH_CYCLES  = CLK_HZ / 1000 * FLASH_MS;
  localparam int PAUSE_CYCLES  = CLK_HZ / 1000 * PAUSE_MS;
  localparam int CNT_W         = 26;

  typedef struct packed {
    logic       overcurrent_error;
    logic       overvoltage_error;
    logic       motor_overload_error;
    logic       device_overload_error;
    logic       motor_overtemp_error;
    logic       device_overheat_error;
    logic       undervoltage_error;
    logic       other_error;
    logic [2:0] other_reaction;
    logic [7:0] location;
  } frled_err_t;

  typedef struct packed {
    logic       active;
    logic       warning;
    logic [2:0] reaction;
    logic [3:0] flash_count;
    logic [7:0] location;
  } frled_report_t;
endpackage : frled_pkg
`default_nettype wire

// ===== frled_top.sv
`default_nettype none
module frled_top
  import frled_pkg::*;
#(
  parameter int FLASH_LEN = FLASH_CYCLES,
  parameter int PAUSE_LEN = PAUSE_CYCLES
) (
  input  wire logic          clk_in,
  input  wire logic          reset_in,
  input  wire frled_err_t    err_in,
  input  wire logic          err_strobe_in,
  input  wire logic          power_stage_enable_input_in,
  input  wire logic          control_enable_in,
  input  wire logic          start_signal_in,
  input  wire logic          autostart_in,
  input  wire logic          error_reset_in,
  output var  logic          power_stage_disable_out,
  output var  logic          quick_stop_out,
  output var  logic          restart_block_out,
  output var  logic          red_indicator_out,
  output var  logic          yellow_indicator_out,
  output var  logic          green_indicator_out,
  output var  frled_report_t report_out
);

  typedef enum logic [1:0] {FRLED_IDLE, FRLED_FAULT, FRLED_WAIT_START, FRLED_LATCHED} frled_state_t;
  typedef enum logic [1:0] {FRLED_DARK, FRLED_ON, FRLED_OFF, FRLED_GAP} frled_flash_t;

  // Pin inputs, two-stage synchronised
  logic [1:0] ena_sync, ctl_sync, start_sync, rst_sync;
  frled_state_t state, next_state;
  frled_report_t report, next_report;
  logic disable_q, next_disable_q, qstop, next_qstop, lock, next_lock;
  frled_flash_t fstate, next_fstate;
  logic [CNT_W-1:0] tick, next_tick;
  logic [3:0] fcount, next_fcount;
  logic [CNT_W-1:0] blink, next_blink;
  logic red, next_red, yellow, next_yellow, green, next_green;
  logic [2:0] new_react;
  logic [3:0] new_flash;
  logic new_err;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ena_sync <= 2'h0;
      ctl_sync <= 2'h0;
      start_sync <= 2'h0;
      rst_sync <= 2'h0;
    end else begin
      ena_sync <= {ena_sync[0], power_stage_enable_input_in};
      ctl_sync <= {ctl_sync[0], control_enable_in};
      start_sync <= {start_sync[0], start_signal_in};
      rst_sync <= {rst_sync[0], error_reset_in};
    end
  end

  // Error classification
  always_comb begin
    new_err = err_strobe_in;
    new_react = err_in.other_reaction;
    new_flash = FLASH_GENERIC;
    if (err_in.undervoltage_error) begin
      new_react = REACT_DISABLE;
      new_flash = FLASH_UNDERV;
    end else if (err_in.overcurrent_error) begin
      new_react = REACT_LOCK;
      new_flash = FLASH_OVERCUR;
    end else if (err_in.overvoltage_error) begin
      new_react = REACT_LOCK;
      new_flash = FLASH_OVERVOLT;
    end else if (err_in.motor_overload_error) begin
      new_react = REACT_LOCK;
      new_flash = FLASH_MOT_OVLD;
    end else if (err_in.device_overload_error) begin
      new_react = REACT_LOCK;
      new_flash = FLASH_DEV_OVLD;
    end else if (err_in.motor_overtemp_error) begin
      new_react = REACT_LOCK;
      new_flash = FLASH_MOT_HOT;
    end else if (err_in.device_overheat_error) begin
      new_react = REACT_LOCK;
      new_flash = FLASH_DEV_HOT;
    end else if (err_in.other_error) begin
      new_react = (err_in.other_reaction > REACT_POWERCUT) ? REACT_POWERCUT : err_in.other_reaction;
    end else begin
      new_err = 1'b0;
    end
  end

  // Reaction sequencer
  always_comb begin
    next_state = state;
    next_report = report;
    next_disable_q = disable_q;
    next_qstop = qstop;
    next_lock = lock;
    // A new error is taken unless a power-cut fault already holds
    if (new_err && state != FRLED_LATCHED) begin
      next_report = '{active: 1'b1, warning: (new_react == REACT_WARN), reaction: new_react,
                      flash_count: new_flash, location: err_in.location};
      case (new_react)
        REACT_WARN: begin
          if (state == FRLED_IDLE) begin
            next_state = FRLED_IDLE;
          end
        end
        REACT_DISABLE: begin
          next_state = FRLED_FAULT;
          next_disable_q = 1'b1;
          next_qstop = 1'b0;
        end
        REACT_QSTOP: begin
          next_state = FRLED_WAIT_START;
          next_qstop = 1'b1;
        end
        REACT_LOCK: begin
          next_state = FRLED_FAULT;
          next_disable_q = 1'b1;
          next_qstop = 1'b0;
          next_lock = autostart_in;
        end
        REACT_QS_LOCK: begin
          next_state = FRLED_WAIT_START;
          next_qstop = 1'b1;
          next_lock = autostart_in;
        end
        default: begin
          next_state = FRLED_LATCHED;
          next_disable_q = 1'b1;
          next_qstop = 1'b0;
        end
      endcase
    end else begin
      case (state)
        FRLED_IDLE: begin
          if (rst_sync[1] && report.warning) begin
            next_report.active = 1'b0;
            next_report.warning = 1'b0;
          end
        end
        FRLED_WAIT_START: begin
          if (!start_sync[1]) begin
            next_qstop = 1'b0;
            next_disable_q = 1'b1;
            next_state = FRLED_FAULT;
          end
        end
        FRLED_FAULT: begin
          if (rst_sync[1] && !start_sync[1]) begin
            next_state = FRLED_IDLE;
            next_disable_q = 1'b0;
            next_report = '0;
          end
        end
        FRLED_LATCHED: begin
          next_state = FRLED_LATCHED;
        end
        default: begin
          next_state = FRLED_IDLE;
        end
      endcase
      // Block ends once idle and released
      if (state == FRLED_IDLE && start_sync[1] == 1'b0 && !report.active) begin
        next_lock = 1'b0;
      end
    end
    if (!autostart_in) begin
      next_lock = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= FRLED_IDLE;
      report <= '0;
      disable_q <= 1'b0;
      qstop <= 1'b0;
      lock <= 1'b0;
    end else begin
      state <= next_state;
      report <= next_report;
      disable_q <= next_disable_q;
      qstop <= next_qstop;
      lock <= next_lock;
    end
  end

  // Red flash code and yellow blink
  always_comb begin
    next_fstate = fstate;
    next_tick = tick;
    next_fcount = fcount;
    next_red = 1'b0;
    next_blink = (blink >= CNT_W'(2 * FLASH_LEN - 1)) ? '0 : blink + 1'b1;
    next_yellow = 1'b0;
    next_green = 1'b1;
    case (fstate)
      FRLED_DARK: begin
        if (report.active && !report.warning) begin
          next_fstate = FRLED_ON;
          next_tick = '0;
          next_fcount = report.flash_count;
        end
      end
      FRLED_ON: begin
        next_red = 1'b1;
        next_tick = tick + 1'b1;
        if (tick >= CNT_W'(FLASH_LEN - 1)) begin
          next_tick = '0;
          next_fcount = fcount - 4'h1;
          next_fstate = (fcount == 4'h1) ? FRLED_GAP : FRLED_OFF;
        end
      end
      FRLED_OFF: begin
        next_tick = tick + 1'b1;
        if (tick >= CNT_W'(FLASH_LEN - 1)) begin
          next_tick = '0;
          next_fstate = FRLED_ON;
        end
      end
      FRLED_GAP: begin
        next_tick = tick + 1'b1;
        if (tick >= CNT_W'(PAUSE_LEN - 1)) begin
          next_fstate = FRLED_DARK;
        end
      end
      default: begin
        next_fstate = FRLED_DARK;
      end
    endcase
    if (!report.active || report.warning) begin
      next_fstate = FRLED_DARK;
      next_red = report.warning;
      if (ctl_sync[1]) begin
        next_yellow = (blink < CNT_W'(FLASH_LEN));
      end else begin
        next_yellow = ena_sync[1];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fstate <= FRLED_DARK;
      tick <= '0;
      fcount <= 4'h0;
      blink <= '0;
      red <= 1'b0;
      yellow <= 1'b0;
      green <= 1'b1;
    end else begin
      fstate <= next_fstate;
      tick <= next_tick;
      fcount <= next_fcount;
      blink <= next_blink;
      red <= next_red;
      yellow <= next_yellow;
      green <= next_green;
    end
  end

  assign power_stage_disable_out = disable_q;
  assign quick_stop_out = qstop;
  assign restart_block_out = lock;
  assign red_indicator_out = red;
  assign yellow_indicator_out = yellow;
  assign green_indicator_out = green;
  assign report_out = report;

  // Fault paths
  undervolt_react_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (err_strobe_in && err_in.undervoltage_error && state != FRLED_LATCHED)
      |=> (report.flash_count == FLASH_UNDERV && disable_q))
    else $error("undervoltage not mapped to two flashes and disable");
  lock_react_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (err_strobe_in && !err_in.undervoltage_error && err_in.overcurrent_error && state != FRLED_LATCHED)
      |=> (report.reaction == REACT_LOCK && report.flash_count == FLASH_OVERCUR))
    else $error("overcurrent not mapped to reaction three");
  powercut_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (state == FRLED_LATCHED) |=> (state == FRLED_LATCHED && disable_q))
    else $error("power-cut fault released");
  lock_autostart_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (!autostart_in) |=> !lock)
    else $error("restart block without autostart");
  qstop_wait_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (state == FRLED_WAIT_START && start_sync[1] && !err_strobe_in) |=> qstop)
    else $error("quick-stop dropped before start withdrawn");
  error_yellow_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (report.active && !report.warning) |=> !yellow)
    else $error("yellow lit during error");
  ready_yellow_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (!report.active && ena_sync[1] && !ctl_sync[1]) |=> yellow)
    else $error("yellow dark when ready");
  warning_only_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (state == FRLED_IDLE && err_strobe_in && new_react == REACT_WARN && new_err && !disable_q)
      |=> (!disable_q && !qstop && state == FRLED_IDLE))
    else $error("warning changed drive state");
endmodule : frled_top
`default_nettype wire

// ===== frled_drive_model.sv
`default_nettype none
module frled_drive_model
  import frled_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic disable_in,
  input  wire logic quick_stop_in,
  input  wire logic start_req_in,
  input  wire logic enable_req_in,
  output var  logic start_signal_out,
  output var  logic stage_enable_out,
  output var  logic control_enable_out,
  output var  logic running_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    start_signal_out = 1'b0;
    stage_enable_out = 1'b0;
    control_enable_out = 1'b0;
  end
  // Operator levels change just after the edge
  always @(posedge clk_in) begin
    start_signal_out <= #1 start_req_in;
    stage_enable_out <= #1 enable_req_in;
    control_enable_out <= #1 enable_req_in & start_req_in;
  end
  // Motor turns only while enabled and not stopped
  assign running_out = stage_enable_out & ~disable_in & ~quick_stop_in;
endmodule : frled_drive_model
`default_nettype wire

// ===== tb_frled_top.sv
`default_nettype none
module tb_frled_top
  import frled_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, reset_in = 1'b1, strobe = 1'b0, autostart = 1'b0, err_reset = 1'b0;
  logic start_req = 1'b0, enable_req = 1'b0, start_s, enable_s, ctrl_s, running;
  logic dis, qs, lock, red, yel, grn;
  frled_err_t    err = '0;
  frled_report_t rep;
  int fail_count = 0, n_tests = 0;
  always #10 clk_in = ~clk_in;
  frled_top #(.FLASH_LEN(4), .PAUSE_LEN(10)) u_frled_top (.clk_in(clk_in), .reset_in(reset_in),
    .err_in(err), .err_strobe_in(strobe), .power_stage_enable_input_in(enable_s),
    .control_enable_in(ctrl_s), .start_signal_in(start_s), .autostart_in(autostart),
    .error_reset_in(err_reset), .power_stage_disable_out(dis), .quick_stop_out(qs),
    .restart_block_out(lock), .red_indicator_out(red), .yellow_indicator_out(yel),
    .green_indicator_out(grn), .report_out(rep));
  frled_drive_model u_frled_drive_model (.clk_in(clk_in), .disable_in(dis), .quick_stop_in(qs),
    .start_req_in(start_req), .enable_req_in(enable_req), .start_signal_out(start_s),
    .stage_enable_out(enable_s), .control_enable_out(ctrl_s), .running_out(running));
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %b", $time, what, got);
    end
  endtask : chk_bit
  task automatic chk_rep(input frled_report_t exp);
    n_tests++;
    if (rep !== exp) begin
      fail_count++;
      $display("Error at %0t: report %h expected %h", $time, rep, exp);
    end
  endtask : chk_rep
  task automatic chk_num(input int got, input int exp, input string what);
    n_tests++;
    if (got != exp) begin
      fail_count++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : chk_num
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic do_reset();
    @(posedge clk_in) #1 reset_in = 1'b1;
    cyc(6);
    reset_in = 1'b0;
    chk_bit(grn, 1'b1, "green");
    chk_bit(dis | qs | lock | red | yel, 1'b0, "outputs after reset");
    cyc(4);
  endtask : do_reset
  task automatic raise(input logic [7:0] f, input logic [2:0] rx);
    @(posedge clk_in) #1 err = {f, rx, 8'hA5};
    strobe = 1'b1;
    cyc(1);
    strobe = 1'b0;
    cyc(1);
  endtask : raise
  // Number of lit cycles of one lamp over one yellow blink period
  task automatic lit(input bit sel, output int n);
    n = 0;
    repeat (8) begin
      n += (sel ? yel : red) === 1'b1;
      cyc(1);
    end
  endtask : lit
  // Flashes between two pauses longer than one dark phase
  task automatic flashes(output int n);
    int dark;
    n = 0;
    dark = 0;
    for (int k = 0; k < 400 && dark < 7; k++) begin
      dark = (red === 1'b0) ? dark + 1 : 0;
      cyc(1);
    end
    dark = 0;
    for (int k = 0; k < 400 && dark < 7; k++) begin
      if (red === 1'b1 && dark > 0) n++;
      dark = (red === 1'b0) ? dark + 1 : 0;
      if (k == 0 && red === 1'b1) n++;
      cyc(1);
    end
  endtask : flashes
  task automatic t_codes();
    int n, fl;
    for (int i = 7; i >= 1; i--) begin
      fl = (i >= 2) ? 10 - i : 2;
      do_reset();
      raise(8'h01 << i, 3'h0);
      chk_rep({1'b1, 1'b0, (i >= 2) ? 3'h3 : 3'h1, 4'(fl), 8'hA5});
      chk_bit(dis, 1'b1, "disable");
      chk_bit(yel, 1'b0, "yellow on error");
      flashes(n);
      chk_num(n, fl, "flash count");
    end
  endtask : t_codes
  task automatic t_react();
    for (int rx = 1; rx <= 4; rx++) begin
      autostart = 1'b1;
      start_req = 1'b1;
      enable_req = 1'b1;
      do_reset();
      chk_bit(running, 1'b1, "stage running before error");
      raise(8'h01, 3'(rx));
      chk_rep({1'b1, 1'b0, 3'(rx), 4'h1, 8'hA5});
      chk_bit(qs, rx == 2 || rx == 4, "quick stop");
      chk_bit(lock, rx >= 3, "restart block");
      chk_bit(running, 1'b0, "stage running");
      start_req = 1'b0;
      cyc(6);
      chk_bit(qs, 1'b0, "quick stop after start off");
      chk_bit(dis, 1'b1, "disable held");
      err_reset = 1'b1;
      cyc(6);
      err_reset = 1'b0;
      chk_bit(dis, 1'b0, "disable after error reset");
    end
    enable_req = 1'b0;
  endtask : t_react
  task automatic t_autostart();
    autostart = 1'b0;
    do_reset();
    raise(8'h80, 3'h0);
    chk_bit(lock, 1'b0, "restart block without autostart");
  endtask : t_autostart
  task automatic t_warn();
    int n;
    enable_req = 1'b1;
    start_req = 1'b1;
    do_reset();
    raise(8'h01, 3'h0);
    chk_rep({1'b1, 1'b1, 3'h0, 4'h1, 8'hA5});
    chk_bit(dis | qs, 1'b0, "action on warning");
    chk_bit(running, 1'b1, "stage running");
    lit(1'b0, n);
    chk_num(n, 8, "red during warning");
    lit(1'b1, n);
    chk_num(n, 4, "yellow blink");
    chk_bit(grn, 1'b1, "green");
    start_req = 1'b0;
    err_reset = 1'b1;
    cyc(6);
    err_reset = 1'b0;
    chk_bit(rep.active, 1'b0, "warning cleared");
    lit(1'b1, n);
    chk_num(n, 8, "yellow when ready");
    lit(1'b0, n);
    chk_num(n, 0, "red when ready");
    enable_req = 1'b0;
  endtask : t_warn
  task automatic t_latch();
    do_reset();
    // Out-of-range reaction code is taken as the power-cut reaction
    raise(8'h01, 3'h7);
    err_reset = 1'b1;
    cyc(6);
    err_reset = 1'b0;
    raise(8'h80, 3'h0);
    chk_rep({1'b1, 1'b0, 3'h5, 4'h1, 8'hA5});
    chk_bit(dis, 1'b1, "disable in latched state");
  endtask : t_latch
  initial begin
    #200000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    t_codes();
    t_react();
    t_autostart();
    t_warn();
    t_latch();
    finish_test();
  end
endmodule : tb_frled_top
`default_nettype wire
